// [logic/servo_cmd_pkg.sv]
package servo_cmd_pkg;

	// Command codes understood by the slave station
	localparam logic [7:0]  CMD_STAT_RD    = 8'h01;
	localparam logic [7:0]  CMD_PAR_RD     = 8'h05;
	localparam logic [7:0]  CMD_STAT_CLR   = 8'h81;
	localparam logic [7:0]  CMD_PAR_WR     = 8'h84;
	localparam logic [7:0]  CMD_GROUP      = 8'h9F;
	// Data numbers and keys
	localparam logic [7:0]  DNUM_ZERO      = 8'h00;
	localparam logic [7:0]  PAR_LAST       = 8'h5A;
	localparam int          PAR_COUNT      = 32'h0000_005B;
	localparam logic [15:0] CLEAR_KEY      = 16'h1EA5;
	// Group letters as ASCII codes, lower case a to f
	localparam logic [7:0]  GROUP_FIRST    = 8'h61;
	localparam logic [7:0]  GROUP_LAST     = 8'h66;
	localparam logic [7:0]  GROUP_RST      = 8'h00;
	// Write modes carried in the set data
	localparam logic [3:0]  WMODE_EEP      = 4'h0;
	localparam logic [3:0]  WMODE_RAM      = 4'h3;
	// Write inhibit parameter and the read enable it steers
	localparam logic [6:0]  PAR_INHIBIT    = 7'h13;
	localparam logic [31:0] RD_ALL         = 32'h0000_0000;
	localparam logic [6:0]  RD_BASIC_LIMIT = 7'h14;
	// Reset values
	localparam logic [31:0] RAM_RST        = 32'h0000_0000;
	localparam logic [6:0]  IDX_RST        = 7'h00;

	// Decoded request from the frame receiver
	typedef struct packed {
		logic [7:0]  cmd;
		logic [7:0]  dnum;
		logic [3:0]  wmode;
		logic [3:0]  dp;
		logic [31:0] data;
	} cmd_req_t;

	// Reply handed to the frame transmitter
	typedef struct packed {
		logic        err;
		logic        rd_en;
		logic [3:0]  disp;
		logic [3:0]  dp;
		logic [31:0] data;
	} cmd_rsp_t;

	// Attributes of one parameter, from the attribute table
	typedef struct packed {
		logic        decimal;
		logic [3:0]  disp;
		logic [3:0]  dp;
		logic [31:0] lo;
		logic [31:0] hi;
	} par_info_t;

	// One monitor item with its processing information
	typedef struct packed {
		logic [3:0]  disp;
		logic [3:0]  dp;
		logic [31:0] value;
	} mon_info_t;

	// Nonvolatile store request
	typedef struct packed {
		logic [6:0]  idx;
		logic [31:0] value;
	} eep_wr_t;

endpackage

// [logic/servo_cmd_data_processing.sv]
// Operation
// - Group command stores letter a to f
// - Decimal write without position is refused
// - Status read returns value with processing info
// - Keyed clear zeroes the item just read
// - Parameter read covers 00 to 5A
// - Data number is parameter index in hex
// - Read enable follows parameter 19 inhibit
// - Write carries mode, position, hex value
// - Mode three RAM only, zero also EEPROM
// - Status data number selects one item
`timescale 1ns/1ps
module servo_cmd_data_processing (
	input  wire logic                     i_clk,
	input  wire logic                     i_rst,
	input  wire logic                     i_req_valid,
	input  wire servo_cmd_pkg::cmd_req_t  i_req,
	input  wire servo_cmd_pkg::par_info_t i_par_info,
	input  wire servo_cmd_pkg::mon_info_t i_mon,
	output logic                          o_busy,
	output logic                          o_rsp_valid,
	output servo_cmd_pkg::cmd_rsp_t       o_rsp,
	output logic [7:0]                    o_group,
	output logic [7:0]                    o_mon_sel,
	output logic                          o_mon_clr,
	output logic [6:0]                    o_par_idx,
	output logic                          o_eep_valid,
	output servo_cmd_pkg::eep_wr_t        o_eep
);

	typedef enum logic {ST_IDLE, ST_LOOK} state_t;

	state_t                  state_reg;    // Idle or waiting on lookups
	state_t                  state_next;   // Next state
	servo_cmd_pkg::cmd_req_t req_reg;      // Captured request
	servo_cmd_pkg::cmd_rsp_t rsp_next;     // Reply being built
	logic                    last_rd_reg;  // Previous command was status read
	logic [31:0]             ram_reg [0:servo_cmd_pkg::PAR_COUNT-1];
	logic                    accept;       // Request taken this cycle
	logic                    look;         // Lookups are valid
	logic                    is_stat_rd;   // Status display read
	logic                    is_par_rd;    // Parameter read in range
	logic                    is_par_wr;    // Parameter write in range
	logic                    is_group;     // Group setting
	logic                    is_clr;       // Keyed status clear
	logic                    group_ok;     // Letter in a to f
	logic                    mode_ok;      // Known write mode
	logic                    dp_ok;        // Position code fits the value type
	logic                    range_ok;     // Value inside the limits
	logic                    wr_ok;        // Write is accepted
	logic                    rd_en_w;      // Read enable of the addressed one
	logic [31:0]             cur_par;      // Stored value of the addressed one

	// Command decode on the captured request
	assign accept     = i_req_valid && (state_reg == ST_IDLE);
	assign look       = (state_reg == ST_LOOK);
	assign is_stat_rd = req_reg.cmd == servo_cmd_pkg::CMD_STAT_RD;
	assign is_par_rd  = (req_reg.cmd == servo_cmd_pkg::CMD_PAR_RD) &&
		(req_reg.dnum <= servo_cmd_pkg::PAR_LAST);
	assign is_par_wr  = (req_reg.cmd == servo_cmd_pkg::CMD_PAR_WR) &&
		(req_reg.dnum <= servo_cmd_pkg::PAR_LAST);
	assign is_group   = (req_reg.cmd == servo_cmd_pkg::CMD_GROUP) &&
		(req_reg.dnum == servo_cmd_pkg::DNUM_ZERO);
	assign is_clr     = (req_reg.cmd == servo_cmd_pkg::CMD_STAT_CLR) &&
		(req_reg.dnum == servo_cmd_pkg::DNUM_ZERO) &&
		(req_reg.data[15:0] == servo_cmd_pkg::CLEAR_KEY);

	// Group letter check
	assign group_ok = (req_reg.data[7:0] >= servo_cmd_pkg::GROUP_FIRST) &&
		(req_reg.data[7:0] <= servo_cmd_pkg::GROUP_LAST);

	// Write checks: mode, position code and limits
	assign mode_ok  = (req_reg.wmode == servo_cmd_pkg::WMODE_EEP) ||
		(req_reg.wmode == servo_cmd_pkg::WMODE_RAM);
	assign dp_ok    = i_par_info.decimal ?
		(req_reg.dp == i_par_info.dp) : (req_reg.dp == 4'h0);
	assign range_ok = (req_reg.data >= i_par_info.lo) &&
		(req_reg.data <= i_par_info.hi);
	assign wr_ok    = is_par_wr && mode_ok && dp_ok && range_ok;

	// Read enable derived from the write inhibit parameter
	assign cur_par = ram_reg[o_par_idx];
	assign rd_en_w = (ram_reg[servo_cmd_pkg::PAR_INHIBIT] ==
		servo_cmd_pkg::RD_ALL) ||
		(o_par_idx < servo_cmd_pkg::RD_BASIC_LIMIT);

	// Next state: one lookup cycle per request
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			ST_IDLE: begin
				if (accept) begin
					state_next = ST_LOOK;
				end
			end
			ST_LOOK: begin
				state_next = ST_IDLE;
			end
		endcase
	end

	// Reply contents for each command
	always_comb begin
		rsp_next = '0;
		if (is_stat_rd) begin
			// Item value with its processing information
			rsp_next.rd_en = 1'b1;
			rsp_next.disp  = i_mon.disp;
			rsp_next.dp    = i_mon.dp;
			rsp_next.data  = i_mon.value;
		end else if (is_par_rd) begin
			// Data part is blanked when reading is disabled
			rsp_next.rd_en = rd_en_w;
			rsp_next.disp  = i_par_info.disp;
			rsp_next.dp    = i_par_info.dp;
			rsp_next.data  = rd_en_w ? cur_par : '0;
		end else if (is_par_wr) begin
			rsp_next.err = !wr_ok;
		end else if (is_group) begin
			rsp_next.err = !group_ok;
		end else if (is_clr) begin
			// Clear without a read just before it is refused
			rsp_next.err = !last_rd_reg;
		end else begin
			// Unknown command, bad data number or bad key
			rsp_next.err = 1'b1;
		end
	end

	// Sequencer and request capture
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			state_reg <= ST_IDLE;
			req_reg   <= '0;
			o_busy    <= 1'b0;
		end else begin
			state_reg <= state_next;
			o_busy    <= (state_next != ST_IDLE);
			if (accept) begin
				req_reg <= i_req;
			end
		end
	end

	// Lookup selects driven straight from the incoming request
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_par_idx <= servo_cmd_pkg::IDX_RST;
			o_mon_sel <= 8'h00;
		end else if (accept) begin
			// Data number is binary, its value is the index
			o_par_idx <= i_req.dnum[6:0];
			if (i_req.cmd == servo_cmd_pkg::CMD_STAT_RD) begin
				o_mon_sel <= i_req.dnum;
			end
		end
	end

	// Reply, group membership and status clear
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_rsp_valid <= 1'b0;
			o_rsp       <= '0;
			o_group     <= servo_cmd_pkg::GROUP_RST;
			o_mon_clr   <= 1'b0;
			last_rd_reg <= 1'b0;
		end else begin
			o_rsp_valid <= look;
			o_mon_clr   <= look && is_clr && last_rd_reg;
			if (look) begin
				o_rsp       <= rsp_next;
				last_rd_reg <= is_stat_rd;
				if (is_group && group_ok) begin
					o_group <= req_reg.data[7:0];
				end
			end
		end
	end

	// Parameter RAM copy and nonvolatile store request
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			for (int i = 0; i < servo_cmd_pkg::PAR_COUNT; i++) begin
				ram_reg[i] <= servo_cmd_pkg::RAM_RST;
			end
			o_eep_valid <= 1'b0;
			o_eep       <= '0;
		end else begin
			o_eep_valid <= look && wr_ok &&
				(req_reg.wmode == servo_cmd_pkg::WMODE_EEP);
			if (look && wr_ok) begin
				// Both modes update the RAM copy
				ram_reg[o_par_idx] <= req_reg.data;
				o_eep.idx          <= o_par_idx;
				o_eep.value        <= req_reg.data;
			end
		end
	end

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);

	// Request taken, then lookup cycle, then reply
	sequence s_taken;
		accept;
	endsequence
	sequence s_answer;
		o_busy ##1 (o_rsp_valid && !o_busy);
	endsequence

	a_reply_timing: assert property (s_taken |=> s_answer)
		else $error("reply not two cycles after request");
	a_group_store: assert property (look && is_group && group_ok |=>
		o_group == $past(req_reg.data[7:0]))
		else $error("group letter not stored");
	a_group_refuse: assert property (look && is_group && !group_ok |=>
		$stable(o_group) && o_rsp.err)
		else $error("bad group letter accepted");
	a_par_index: assert property (accept && i_req.cmd ==
		servo_cmd_pkg::CMD_PAR_RD |=>
		o_par_idx == $past(i_req.dnum[6:0]))
		else $error("parameter index not taken from data number");
	a_stat_value: assert property (look && is_stat_rd |=>
		o_rsp.data == $past(i_mon.value) && !o_rsp.err)
		else $error("status value not returned");
	a_clr_pulse: assert property (look && is_clr && last_rd_reg |=>
		o_mon_clr ##1 !o_mon_clr)
		else $error("status clear pulse wrong");
	a_clr_needs_read: assert property (o_mon_clr |->
		$past(last_rd_reg) && o_rsp_valid && !o_rsp.err)
		else $error("clear without preceding read");
	a_wr_refused: assert property (look && is_par_wr && !wr_ok |=>
		o_rsp.err && !o_eep_valid)
		else $error("refused write had effect");
	a_dp_missing: assert property (look && is_par_wr &&
		i_par_info.decimal && req_reg.dp != i_par_info.dp |=>
		o_rsp.err)
		else $error("decimal write without position accepted");
	a_ram_only: assert property (look && wr_ok &&
		req_reg.wmode == servo_cmd_pkg::WMODE_RAM |=>
		!o_eep_valid && !o_rsp.err)
		else $error("RAM mode reached nonvolatile store");
	a_eep_store: assert property (look && wr_ok &&
		req_reg.wmode == servo_cmd_pkg::WMODE_EEP |=>
		o_eep_valid && o_eep.value == $past(req_reg.data))
		else $error("EEPROM mode did not store");
	a_rd_disable: assert property (look && is_par_rd && !rd_en_w |=>
		!o_rsp.rd_en && o_rsp.data == 32'h0000_0000)
		else $error("disabled read returned data");

endmodule

// [tb/servo_attr_model.sv]
`timescale 1ns/1ps
module servo_attr_model (
	input  wire logic [6:0]          i_par_idx,
	input  wire logic [7:0]          i_mon_sel,
	output servo_cmd_pkg::par_info_t o_par_info,
	output servo_cmd_pkg::mon_info_t o_mon
);
	// Odd parameters are decimal with two places, even ones are hex
	assign o_par_info.decimal = i_par_idx[0];
	assign o_par_info.disp    = {3'h0, ~i_par_idx[0]};
	assign o_par_info.dp      = i_par_idx[0] ? 4'h2 : 4'h0;
	// Narrow range so that an oversize value must be refused
	assign o_par_info.lo      = 32'h0000_0000;
	assign o_par_info.hi      = 32'h0000_FFFF;
	// Monitor value follows the selected item so a mixup shows
	assign o_mon.disp         = 4'h0;
	assign o_mon.dp           = 4'h3;
	assign o_mon.value        = {24'h00_0900, i_mon_sel};
endmodule

// [tb/testbench.sv]
`timescale 1ns/1ps
`define CHK(g, e, m) begin num_checks++; if ((g) !== (e)) begin \
	n_mismatch++; $display("MISMATCH t=%0t %s", $time, m); end end
module testbench;
	logic                      i_clk;       // Bench clock
	logic                      i_rst;       // Reset, active high
	logic                      i_req_valid; // Request strobe
	servo_cmd_pkg::cmd_req_t   i_req;       // Request fields
	servo_cmd_pkg::par_info_t  par_info;    // Attributes from model
	servo_cmd_pkg::mon_info_t  mon;         // Monitor item from model
	logic                      o_busy;
	logic                      o_rsp_valid;
	servo_cmd_pkg::cmd_rsp_t   o_rsp;
	logic [7:0]                o_group;
	logic [7:0]                o_mon_sel;
	logic                      o_mon_clr;
	logic [6:0]                o_par_idx;
	logic                      o_eep_valid;
	servo_cmd_pkg::eep_wr_t    o_eep;
	servo_cmd_pkg::cmd_rsp_t   rsp;         // Captured reply
	servo_cmd_pkg::eep_wr_t    eep;         // Captured store request
	logic                      eepv;        // Store pulse at reply
	logic                      clr;         // Clear pulse at reply
	int                        n_mismatch;  // Mismatch count
	int                        num_checks;  // Comparison count

	servo_cmd_data_processing servo_cmd_data_processing_i (
		.i_clk(i_clk), .i_rst(i_rst), .i_req_valid(i_req_valid),
		.i_req(i_req), .i_par_info(par_info), .i_mon(mon),
		.o_busy(o_busy), .o_rsp_valid(o_rsp_valid), .o_rsp(o_rsp),
		.o_group(o_group), .o_mon_sel(o_mon_sel), .o_mon_clr(o_mon_clr),
		.o_par_idx(o_par_idx), .o_eep_valid(o_eep_valid), .o_eep(o_eep)
	);
	servo_attr_model servo_attr_model_i (
		.i_par_idx(o_par_idx), .i_mon_sel(o_mon_sel),
		.o_par_info(par_info), .o_mon(mon)
	);

	// Free running clock, 100 ns period
	initial begin
		i_clk = 1'b0;
		forever #50 i_clk = ~i_clk;
	end

	// One request, then wait for its reply and capture it
	task automatic send(input logic [7:0] c, input logic [7:0] d,
		input logic [3:0] w, input logic [3:0] p, input logic [31:0] v);
		int k;
		@(negedge i_clk);
		i_req <= '{cmd: c, dnum: d, wmode: w, dp: p, data: v};
		i_req_valid <= 1'b1;
		@(negedge i_clk);
		i_req_valid <= 1'b0;
		`CHK(o_busy, 1'b1, "busy in flight")
		k = 0;
		while (o_rsp_valid !== 1'b1 && k < 8) begin
			@(negedge i_clk);
			k++;
		end
		`CHK(k, 1, "reply latency")
		rsp = o_rsp;
		eep = o_eep;
		eepv = o_eep_valid;
		clr = o_mon_clr;
	endtask

	// Parameter read shorthand
	task automatic rd(input logic [7:0] d);
		send(8'h05, d, 4'h0, 4'h0, 32'h0000_0000);
	endtask

	// Print counts and verdict, then stop
	task automatic final_report;
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// Watchdog against a hung handshake
	initial begin
		#(2000 * 100);
		n_mismatch++;
		final_report;
	end

	// Main sequence
	initial begin
		i_rst = 1'b1;
		i_req_valid = 1'b0;
		i_req = '0;
		n_mismatch = 0;
		num_checks = 0;
		repeat (6) @(posedge i_clk);
		@(negedge i_clk);
		i_rst = 1'b0;
		`CHK(o_group, 8'h00, "group after reset")
		// Every letter a to f is taken
		for (int g = 8'h61; g <= 8'h66; g++) begin
			send(8'h9F, 8'h00, 4'h0, 4'h0, 32'(g));
			`CHK(rsp.err, 1'b0, "group accepted")
			`CHK(o_group, 8'(g), "group letter")
		end
		// Letter past f and nonzero data number are refused
		send(8'h9F, 8'h00, 4'h0, 4'h0, 32'h0000_0067);
		`CHK(rsp.err, 1'b1, "letter g refused")
		send(8'h9F, 8'h01, 4'h0, 4'h0, 32'h0000_0061);
		`CHK(rsp.err, 1'b1, "group dnum refused")
		`CHK(o_group, 8'h66, "group kept")
		// Hex parameter to nonvolatile store, position zero
		send(8'h84, 8'h02, 4'h0, 4'h0, 32'h0000_009B);
		`CHK(rsp.err, 1'b0, "eep write ok")
		`CHK(eepv, 1'b1, "eep pulse")
		`CHK(eep, {7'h02, 32'h0000_009B}, "eep content")
		rd(8'h02);
		`CHK(rsp.data, 32'h0000_009B, "read back hex")
		`CHK({rsp.rd_en, rsp.disp}, 5'h11, "hex read info")
		// 1.55 sent as 155 in hex with two places, RAM only
		send(8'h84, 8'h03, 4'h3, 4'h2, 32'h0000_009B);
		`CHK(eepv, 1'b0, "ram write no eep")
		rd(8'h03);
		`CHK(rsp.data, 32'h0000_009B, "ram read back")
		`CHK(rsp.dp, 4'h2, "ram read position")
		// Refused writes leave the value alone
		send(8'h84, 8'h03, 4'h0, 4'h0, 32'h0000_0001);
		`CHK(rsp.err, 1'b1, "missing position")
		`CHK(eepv, 1'b0, "no eep on refusal")
		send(8'h84, 8'h03, 4'h1, 4'h2, 32'h0000_0001);
		`CHK(rsp.err, 1'b1, "bad write mode")
		send(8'h84, 8'h03, 4'h3, 4'h2, 32'h0001_0000);
		`CHK(rsp.err, 1'b1, "out of range")
		send(8'h84, 8'h5B, 4'h3, 4'h0, 32'h0000_0001);
		`CHK(rsp.err, 1'b1, "write past 5A")
		rd(8'h03);
		`CHK(rsp.data, 32'h0000_009B, "value kept")
		rd(8'h5A);
		`CHK(rsp.err, 1'b0, "read 5A")
		rd(8'h5B);
		`CHK(rsp.err, 1'b1, "read past 5A")
		// Write inhibit in parameter 19 blocks upper reads
		send(8'h84, 8'h13, 4'h3, 4'h2, 32'h0000_0001);
		rd(8'h20);
		`CHK({rsp.rd_en, rsp.data}, 33'h0, "upper read off")
		`CHK(o_par_idx, 7'h20, "parameter index")
		rd(8'h03);
		`CHK(rsp.rd_en, 1'b1, "basic read on")
		send(8'h84, 8'h13, 4'h3, 4'h2, 32'h0000_0000);
		rd(8'h20);
		`CHK(rsp.rd_en, 1'b1, "upper read back on")
		// Status read then keyed clear
		send(8'h01, 8'h80, 4'h0, 4'h0, 32'h0000_0000);
		`CHK(rsp.data, 32'h0009_0080, "status value")
		`CHK({rsp.disp, rsp.dp}, 8'h03, "status info")
		`CHK(o_mon_sel, 8'h80, "item select")
		send(8'h81, 8'h00, 4'h0, 4'h0, 32'h0000_1EA5);
		`CHK({rsp.err, clr}, 2'b01, "keyed clear")
		send(8'h81, 8'h00, 4'h0, 4'h0, 32'h0000_1EA5);
		`CHK({rsp.err, clr}, 2'b10, "clear twice")
		send(8'h01, 8'h80, 4'h0, 4'h0, 32'h0000_0000);
		rd(8'h02);
		send(8'h81, 8'h00, 4'h0, 4'h0, 32'h0000_1EA5);
		`CHK({rsp.err, clr}, 2'b10, "clear after other")
		send(8'h01, 8'h80, 4'h0, 4'h0, 32'h0000_0000);
		send(8'h81, 8'h00, 4'h0, 4'h0, 32'h0000_1EA4);
		`CHK({rsp.err, clr}, 2'b10, "wrong key")
		final_report;
	end
endmodule
